// ### shared/poscmp_consts.svh
// Register offsets, field limits, reset values and widths of the position compare channels.
`ifndef POSCMP_CONSTS_SVH
`define POSCMP_CONSTS_SVH

// Parameter address width and data width of the parameter port.
`define PARAM_ADDR_W        16
`define PARAM_DATA_W        32

// Channel 2 parameter offsets.
`define CH2_RUN_CONTROL     16'h0b06
`define CH2_CRITERION       16'h0b0a
`define CH2_SOURCE          16'h0b0e
`define CH2_VALUE_A         16'h0b14
`define CH2_VALUE_B         16'h0b16

// Channel 3 parameter offsets.
`define CH3_RUN_CONTROL     16'h0b18
`define CH3_CRITERION       16'h0b1c
`define CH3_SOURCE          16'h0b20
`define CH3_VALUE_A         16'h0b24
`define CH3_VALUE_B         16'h0b26

// Channel 4 parameter offsets.
`define CH4_RUN_CONTROL     16'h0b1a
`define CH4_CRITERION       16'h0b1e
`define CH4_SOURCE          16'h0b22
`define CH4_VALUE_A         16'h0b28
`define CH4_VALUE_B         16'h0b2a

// Largest legal setting of each selector and the only legal source.
`define CRITERION_MAX       32'h0000_0005
`define RUN_CONTROL_MAX     32'h0000_0003
`define SOURCE_ENCODER1     32'h0000_0000

// Reset values of every setting.
`define RUN_CONTROL_RESET   2'h0
`define CRITERION_RESET     3'h0
`define SOURCE_RESET        16'h0000
`define VALUE_RESET         32'h0000_0000

// Number of channels held by this block.
`define CHANNEL_COUNT       3

`endif

// ### shared/poscmp_pkg.sv
// Types shared by the position compare channels and their parameter file.
package poscmp_pkg;

  // Comparison criterion of one channel.
  typedef enum logic [2:0] {
    CRIT_GE_A      = 3'b000,
    CRIT_LE_A      = 3'b001,
    CRIT_IN_BASIC  = 3'b010,
    CRIT_OUT_BASIC = 3'b011,
    CRIT_IN_EXT    = 3'b100,
    CRIT_OUT_EXT   = 3'b101
  } criterion_t;

  // Start and stop setting of one channel.
  typedef enum logic [1:0] {
    RUN_OFF_HOLD = 2'b00,
    RUN_ON       = 2'b01,
    RUN_OFF_CLR  = 2'b10,
    RUN_OFF_SET  = 2'b11
  } run_ctrl_t;

  // Which setting of a channel an address selects.
  typedef enum logic [2:0] {
    FLD_RUN   = 3'b000,
    FLD_CRIT  = 3'b001,
    FLD_SRC   = 3'b010,
    FLD_VAL_A = 3'b011,
    FLD_VAL_B = 3'b100,
    FLD_NONE  = 3'b111
  } field_t;

  // Full setting of one channel as seen by its comparator.
  typedef struct packed {
    run_ctrl_t          run;
    criterion_t         crit;
    logic [15:0]        source;
    logic signed [31:0] value_a;
    logic signed [31:0] value_b;
  } channel_cfg_t;

  // One actual position sample from encoder 1.
  typedef struct packed {
    logic               valid;
    logic signed [31:0] pos;
  } pos_sample_t;

  // Result of decoding a parameter address.
  typedef struct packed {
    logic       hit;
    logic [1:0] ch;
    field_t     field;
  } reg_decode_t;

endpackage

// ### core/compare_channel.sv
// One position compare channel: criterion evaluation and its status bit.
`timescale 1ns/1ps
`include "poscmp_consts.svh"

module compare_channel
  import poscmp_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         ce,
  // Current channel setting and position sample.
  input  wire channel_cfg_t cfg,
  input  wire pos_sample_t  sample,
  // Channel status bit.
  output logic              status
);

  // The range criteria accept A and B in either order, so the span is ordered here.
  function automatic logic criterion_hit(input criterion_t crit,
                                         input logic signed [31:0] p,
                                         input logic signed [31:0] a,
                                         input logic signed [31:0] b);
    logic signed [31:0] lo;
    logic signed [31:0] hi;
    logic               in_span;
    lo      = (a < b) ? a : b;
    hi      = (a < b) ? b : a;
    in_span = (p >= lo) && (p <= hi);
    case (crit)
      CRIT_GE_A:      criterion_hit = (p >= a);
      CRIT_LE_A:      criterion_hit = (p <= a);
      CRIT_IN_BASIC:  criterion_hit = in_span;
      CRIT_OUT_BASIC: criterion_hit = !in_span;
      // Extended variants compare exactly like the basic ones.
      CRIT_IN_EXT:    criterion_hit = in_span;
      CRIT_OUT_EXT:   criterion_hit = !in_span;
      default:        criterion_hit = 1'b0;
    endcase
  endfunction

  logic hit;

  // Only encoder 1 exists, so any other source never produces a hit.
  assign hit = (cfg.source == `SOURCE_RESET) && criterion_hit(cfg.crit, sample.pos, cfg.value_a, cfg.value_b);

  // Status follows the run setting; forced states apply without waiting for a sample.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status <= 1'b0;
    end else if (ce) begin
      case (cfg.run)
        RUN_OFF_HOLD: status <= status;
        RUN_ON: begin
          if (sample.valid) begin
            status <= hit;
          end
        end
        RUN_OFF_CLR:  status <= 1'b0;
        RUN_OFF_SET:  status <= 1'b1;
        default:      status <= status;
      endcase
    end
  end

endmodule

// ### core/position_compare_channels.sv
// Position compare channels 2 to 4 with their parameter file.
//
// Overview of operation
// - Criterion 0: position at or above A.
// - Criterion 1: position at or below A.
// - Criterion 2: position inside A..B, limits included.
// - Criterion 3: position outside A..B, limits excluded.
// - Criterion 4: position inside A..B, limits included.
// - Criterion 5: position outside A..B, limits excluded.
// - Source accepts only 0, encoder 1 position.
// - Run 0: stop, status keeps last value.
// - Run 1: compare continuously, drive status.
// - Run 2: stop, status forced to 0.
// - Run 3: stop, status forced to 1.
// - Written settings take effect at once.
// - Value A signed 32 bits, resets zero.
// - Value B signed 32 bits, second bound.
// - Channel 4 complete and independent.
`timescale 1ns/1ps
`include "poscmp_consts.svh"

module position_compare_channels
  import poscmp_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic                        ce,
  // Actual position of encoder 1.
  input  wire logic                        pos_valid,
  input  wire logic signed [31:0]          pos_actual,
  // Parameter write port.
  input  wire logic                        wr_en,
  input  wire logic [`PARAM_ADDR_W-1:0]    wr_addr,
  input  wire logic [`PARAM_DATA_W-1:0]    wr_data,
  output logic                             wr_ack,
  output logic                             wr_err,
  // Parameter read port.
  input  wire logic                        rd_en,
  input  wire logic [`PARAM_ADDR_W-1:0]    rd_addr,
  output logic                             rd_valid,
  output logic                             rd_err,
  output logic [`PARAM_DATA_W-1:0]         rd_data,
  // Status bits, bit 0 is channel 2, bit 2 is channel 4.
  output logic [`CHANNEL_COUNT-1:0]        status_bits
);

  // Maps a parameter address to a channel and a setting; misses give hit low.
  function automatic reg_decode_t decode_addr(input logic [`PARAM_ADDR_W-1:0] addr);
    reg_decode_t d;
    d = '{hit: 1'b1, ch: 2'd0, field: FLD_NONE};
    case (addr)
      `CH2_RUN_CONTROL: d = '{hit: 1'b1, ch: 2'd0, field: FLD_RUN};
      `CH2_CRITERION:   d = '{hit: 1'b1, ch: 2'd0, field: FLD_CRIT};
      `CH2_SOURCE:      d = '{hit: 1'b1, ch: 2'd0, field: FLD_SRC};
      `CH2_VALUE_A:     d = '{hit: 1'b1, ch: 2'd0, field: FLD_VAL_A};
      `CH2_VALUE_B:     d = '{hit: 1'b1, ch: 2'd0, field: FLD_VAL_B};
      `CH3_RUN_CONTROL: d = '{hit: 1'b1, ch: 2'd1, field: FLD_RUN};
      `CH3_CRITERION:   d = '{hit: 1'b1, ch: 2'd1, field: FLD_CRIT};
      `CH3_SOURCE:      d = '{hit: 1'b1, ch: 2'd1, field: FLD_SRC};
      `CH3_VALUE_A:     d = '{hit: 1'b1, ch: 2'd1, field: FLD_VAL_A};
      `CH3_VALUE_B:     d = '{hit: 1'b1, ch: 2'd1, field: FLD_VAL_B};
      `CH4_RUN_CONTROL: d = '{hit: 1'b1, ch: 2'd2, field: FLD_RUN};
      `CH4_CRITERION:   d = '{hit: 1'b1, ch: 2'd2, field: FLD_CRIT};
      `CH4_SOURCE:      d = '{hit: 1'b1, ch: 2'd2, field: FLD_SRC};
      `CH4_VALUE_A:     d = '{hit: 1'b1, ch: 2'd2, field: FLD_VAL_A};
      `CH4_VALUE_B:     d = '{hit: 1'b1, ch: 2'd2, field: FLD_VAL_B};
      default:          d = '{hit: 1'b0, ch: 2'd0, field: FLD_NONE};
    endcase
    return d;
  endfunction

  // Setting storage, one entry per channel.
  run_ctrl_t          run_reg   [`CHANNEL_COUNT];
  criterion_t         crit_reg  [`CHANNEL_COUNT];
  logic [15:0]        src_reg   [`CHANNEL_COUNT];
  logic signed [31:0] val_a_reg [`CHANNEL_COUNT];
  logic signed [31:0] val_b_reg [`CHANNEL_COUNT];

  reg_decode_t wr_dec;
  reg_decode_t rd_dec;
  logic        wr_legal;
  pos_sample_t sample;

  assign wr_dec = decode_addr(wr_addr);
  assign rd_dec = decode_addr(rd_addr);
  assign sample = '{valid: pos_valid, pos: pos_actual};

  // Selectors outside their documented range are refused so a channel never holds a code it cannot act on.
  always_comb begin
    case (wr_dec.field)
      FLD_RUN:   wr_legal = (wr_data <= `RUN_CONTROL_MAX);
      FLD_CRIT:  wr_legal = (wr_data <= `CRITERION_MAX);
      FLD_SRC:   wr_legal = (wr_data == `SOURCE_ENCODER1);
      FLD_VAL_A: wr_legal = 1'b1;
      FLD_VAL_B: wr_legal = 1'b1;
      default:   wr_legal = 1'b0;
    endcase
  end

  // Setting writes; each channel has its own storage so channels stay independent.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < `CHANNEL_COUNT; i++) begin
        run_reg[i]   <= run_ctrl_t'(`RUN_CONTROL_RESET);
        crit_reg[i]  <= criterion_t'(`CRITERION_RESET);
        src_reg[i]   <= `SOURCE_RESET;
        val_a_reg[i] <= `VALUE_RESET;
        val_b_reg[i] <= `VALUE_RESET;
      end
    end else if (ce && wr_en && wr_dec.hit && wr_legal) begin
      case (wr_dec.field)
        FLD_RUN:   run_reg[wr_dec.ch]   <= run_ctrl_t'(wr_data[1:0]);
        FLD_CRIT:  crit_reg[wr_dec.ch]  <= criterion_t'(wr_data[2:0]);
        FLD_SRC:   src_reg[wr_dec.ch]   <= wr_data[15:0];
        FLD_VAL_A: val_a_reg[wr_dec.ch] <= wr_data;
        FLD_VAL_B: val_b_reg[wr_dec.ch] <= wr_data;
        default:   run_reg[wr_dec.ch]   <= run_reg[wr_dec.ch];
      endcase
    end
  end

  // Write answer one cycle after the request.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_ack <= 1'b0;
      wr_err <= 1'b0;
    end else if (ce) begin
      wr_ack <= wr_en;
      wr_err <= wr_en && !(wr_dec.hit && wr_legal);
    end
  end

  // Read answer one cycle after the request; narrow settings read zero above their width.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_valid <= 1'b0;
      rd_err   <= 1'b0;
      rd_data  <= 32'h0000_0000;
    end else if (ce) begin
      rd_valid <= rd_en;
      rd_err   <= rd_en && !rd_dec.hit;
      if (rd_en) begin
        case (rd_dec.field)
          FLD_RUN:   rd_data <= {30'h0, run_reg[rd_dec.ch]};
          FLD_CRIT:  rd_data <= {29'h0, crit_reg[rd_dec.ch]};
          FLD_SRC:   rd_data <= {16'h0000, src_reg[rd_dec.ch]};
          FLD_VAL_A: rd_data <= val_a_reg[rd_dec.ch];
          FLD_VAL_B: rd_data <= val_b_reg[rd_dec.ch];
          default:   rd_data <= 32'h0000_0000;
        endcase
      end
    end
  end

  // One comparator per channel, each fed directly from live settings.
  for (genvar g = 0; g < `CHANNEL_COUNT; g++) begin : g_ch
    channel_cfg_t cfg;
    assign cfg = '{run: run_reg[g], crit: crit_reg[g], source: src_reg[g],
                   value_a: val_a_reg[g], value_b: val_b_reg[g]};
    compare_channel u_ch (
      .clk     (clk),
      .reset_n (reset_n),
      .ce      (ce),
      .cfg     (cfg),
      .sample  (sample),
      .status  (status_bits[g])
    );
  end

endmodule

// ### verif/position_compare_channels_chk.sv
// Port checker of the position compare channels.
`timescale 1ns/1ps
`include "poscmp_consts.svh"

module position_compare_channels_chk
  import poscmp_pkg::*;
(
  // Clock, reset and enable.
  input wire logic                     clk,
  input wire logic                     reset_n,
  input wire logic                     ce,
  // Position, parameter port and status.
  input wire logic                     pos_valid,
  input wire logic signed [31:0]       pos_actual,
  input wire logic                     wr_en,
  input wire logic [`PARAM_ADDR_W-1:0] wr_addr,
  input wire logic [`PARAM_DATA_W-1:0] wr_data,
  input wire logic                     wr_ack,
  input wire logic                     wr_err,
  input wire logic                     rd_en,
  input wire logic [`PARAM_ADDR_W-1:0] rd_addr,
  input wire logic                     rd_valid,
  input wire logic                     rd_err,
  input wire logic [`PARAM_DATA_W-1:0] rd_data,
  input wire logic [`CHANNEL_COUNT-1:0] status_bits
);
  // All checks run on one clock and stop while reset is low.
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  wr_answer_a: assert property (ce && wr_en |=> wr_ack)
    else $error("write not answered");
  wr_quiet_a: assert property (ce && !wr_en |=> !wr_ack)
    else $error("write answer without request");
  rd_answer_a: assert property (ce && rd_en |=> rd_valid)
    else $error("read not answered");
  err_pair_a: assert property (wr_err |-> wr_ack)
    else $error("write refusal without answer");
  src_refuse_a: assert property (ce && wr_en && wr_addr == `CH3_SOURCE && wr_data != 32'h0 |=> wr_err)
    else $error("nonzero source accepted");
  force_clear_a: assert property (ce && wr_en && wr_addr == `CH2_RUN_CONTROL && wr_data == 32'h2 ##1 ce
    |=> !status_bits[0])
    else $error("status not forced low");
  force_set_a: assert property (ce && wr_en && wr_addr == `CH2_RUN_CONTROL && wr_data == 32'h3 ##1 ce
    |=> status_bits[0])
    else $error("status not forced high");
  status_still_a: assert property (ce && !pos_valid && !wr_en ##1 ce && !pos_valid && !wr_en
    |=> $stable(status_bits))
    else $error("status moved without sample or write");

  // Main scenarios are reached.
  refused_c: cover property (wr_ack && wr_err);
  unmapped_c: cover property (rd_valid && rd_err);
  ch4_rise_c: cover property ($rose(status_bits[2]));
endmodule

bind position_compare_channels position_compare_channels_chk u_chk (.*);

// ### verif/position_compare_channels_tb_top.sv
// Self-checking bench of the position compare channels.
`timescale 1ns/1ps
`include "poscmp_consts.svh"

module position_compare_channels_tb_top
  import poscmp_pkg::*;
;
  logic               clk = 0, reset_n = 0, ce = 1, pos_valid = 0, wr_en = 0, rd_en = 0;
  logic signed [31:0] pos_actual = 0;
  logic [15:0]        wr_addr = 0, rd_addr = 0;
  logic [31:0]        wr_data = 0, rd_data;
  logic               wr_ack, wr_err, rd_valid, rd_err;
  logic [2:0]         status_bits;
  int                 fails = 0, comparisons = 0;

  // Clock enable stays high so every edge counts, except for the one edge that t_freeze holds it low.
  position_compare_channels DUT (.clk(clk), .reset_n(reset_n), .ce(ce), .pos_valid(pos_valid),
    .pos_actual(pos_actual), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_ack(wr_ack),
    .wr_err(wr_err), .rd_en(rd_en), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_err(rd_err),
    .rd_data(rd_data), .status_bits(status_bits));

  // A 200 MHz clock.
  always #2.5 clk = ~clk;

  // Compare one value and count it.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Print the counts and the verdict, then stop.
  task automatic finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One write; the answer comes exactly one cycle later.
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic e);
    @(posedge clk);
    #1;
    wr_en = 1;
    wr_addr = a;
    wr_data = d;
    @(posedge clk);
    #1;
    wr_en = 0;
    check("wr_ack", {31'h0, wr_ack}, 32'h1);
    check("wr_err", {31'h0, wr_err}, {31'h0, e});
  endtask

  // One read with its expected data and refusal flag.
  task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic e);
    @(posedge clk);
    #1;
    rd_en = 1;
    rd_addr = a;
    @(posedge clk);
    #1;
    rd_en = 0;
    check("rd_valid", {31'h0, rd_valid}, 32'h1);
    check("rd_err", {31'h0, rd_err}, {31'h0, e});
    check("rd_data", rd_data, d);
  endtask

  // One position sample, then the status bit of one channel.
  task automatic smp(input logic signed [31:0] p, input int ch, input logic e);
    @(posedge clk);
    #1;
    pos_valid = 1;
    pos_actual = p;
    @(posedge clk);
    #1;
    pos_valid = 0;
    check("status", {31'h0, status_bits[ch]}, {31'h0, e});
  endtask

  // Expected condition; the range is taken between the lower and the higher bound.
  function automatic logic want(input int c, input int p, input int a, input int b);
    int lo = a < b ? a : b;
    int hi = a < b ? b : a;
    case (c)
      0: return p >= a;
      1: return p <= a;
      2, 4: return p >= lo && p <= hi;
      default: return p < lo || p > hi;
    endcase
  endfunction

  // Reset values, read-back of signed values and refused settings.
  task automatic t_regs;
    logic [15:0] adr [15] = '{`CH2_RUN_CONTROL, `CH2_CRITERION, `CH2_SOURCE, `CH2_VALUE_A, `CH2_VALUE_B,
                              `CH3_RUN_CONTROL, `CH3_CRITERION, `CH3_SOURCE, `CH3_VALUE_A, `CH3_VALUE_B,
                              `CH4_RUN_CONTROL, `CH4_CRITERION, `CH4_SOURCE, `CH4_VALUE_A, `CH4_VALUE_B};
    foreach (adr[i]) rd(adr[i], 32'h0, 0);
    rd(16'h0b00, 32'h0, 1);
    wr(`CH3_VALUE_A, 32'h8000_0001, 0);
    rd(`CH3_VALUE_A, 32'h8000_0001, 0);
    wr(`CH3_VALUE_B, 32'h7fff_ffff, 0);
    rd(`CH3_VALUE_B, 32'h7fff_ffff, 0);
    wr(`CH3_SOURCE, 32'h1, 1);
    rd(`CH3_SOURCE, 32'h0, 0);
    wr(`CH3_CRITERION, 32'h6, 1);
    rd(`CH3_CRITERION, 32'h0, 0);
  endtask

  // Every criterion on channel 3 at and beside both bounds, switched while running.
  task automatic t_crit;
    int pts [5] = '{-11, -10, 0, 20, 21};
    wr(`CH3_VALUE_A, 32'hffff_fff6, 0);
    wr(`CH3_VALUE_B, 32'h0000_0014, 0);
    wr(`CH3_RUN_CONTROL, 32'h1, 0);
    for (int c = 0; c < 6; c++) begin
      wr(`CH3_CRITERION, c, 0);
      foreach (pts[i]) smp(pts[i], 1, want(c, pts[i], -10, 20));
    end
  endtask

  // Run settings of channel 2: on, hold, force low, force high.
  task automatic t_run;
    wr(`CH2_SOURCE, 32'h0, 0);
    wr(`CH2_CRITERION, 32'h1, 0);
    wr(`CH2_RUN_CONTROL, 32'h1, 0);
    smp(-5, 0, 1);
    wr(`CH2_RUN_CONTROL, 32'h0, 0);
    smp(5, 0, 1);
    wr(`CH2_RUN_CONTROL, 32'h2, 0);
    smp(-5, 0, 0);
    wr(`CH2_RUN_CONTROL, 32'h3, 0);
    smp(5, 0, 1);
    wr(`CH2_RUN_CONTROL, 32'h4, 1);
  endtask

  // Channel 4 runs on its own settings beside the others.
  task automatic t_ch4;
    wr(`CH4_VALUE_A, 32'h0000_0064, 0);
    wr(`CH4_VALUE_B, 32'hffff_ff9c, 0);
    rd(`CH4_VALUE_B, 32'hffff_ff9c, 0);
    wr(`CH4_CRITERION, 32'h1, 0);
    wr(`CH4_RUN_CONTROL, 32'h1, 0);
    smp(50, 2, 1);
    check("ch2_status", {31'h0, status_bits[0]}, 32'h1);
    smp(101, 2, 0);
    check("ch3_status", {31'h0, status_bits[1]}, 32'h1);
  endtask

  // Clock enable low must freeze answers, settings and status bits alike.
  task automatic t_freeze;
    @(posedge clk);
    #1;
    ce = 0;
    wr_en = 1;
    wr_addr = `CH4_RUN_CONTROL;
    wr_data = 32'h2;
    pos_valid = 1;
    pos_actual = 0;
    @(posedge clk);
    #1;
    check("frozen_ack", {31'h0, wr_ack}, 32'h0);
    check("frozen_status", {31'h0, status_bits[2]}, 32'h0);
    wr_en = 0;
    pos_valid = 0;
    ce = 1;
    rd(`CH4_RUN_CONTROL, 32'h1, 0);
  endtask

  // A hang ends the run as a failure.
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    finish_test();
  end

  // Reset for ten cycles, then the scenarios.
  initial begin
    repeat (10) @(posedge clk);
    #1;
    reset_n = 1;
    t_regs();
    t_crit();
    t_run();
    t_ch4();
    t_freeze();
    finish_test();
  end
endmodule
